//--- hdl/fsbs_defines.vh
// Constants for the flash status and boot select block
`ifndef FSBS_DEFINES_VH
`define FSBS_DEFINES_VH
// APB register byte addresses
`define FSBS_ADDR_CMDSTAT   12'h000
`define FSBS_ADDR_BOOTCFG   12'h004
`define FSBS_ADDR_START     12'h008
`define FSBS_ADDR_IRQ_STAT  12'h00C
`define FSBS_ADDR_IRQ_MASK  12'h010
`define FSBS_ADDR_CTRL      12'h014
// Status bit positions
`define FSBS_BIT_OI         0
`define FSBS_BIT_SV         1
`define FSBS_BIT_HVE        2
`define FSBS_BIT_HVA        3
`define FSBS_STAT_MASK      8'h0F
// Commands
`define FSBS_CMD_LOAD       8'h00
`define FSBS_CMD_ERASE_PGM  8'h68
// Addresses
`define FSBS_APP_START      16'h0000
`define FSBS_VEC_LOW        8'h00
`define FSBS_ROM_BASE       16'hFF00
`define FSBS_ROM_TOP        16'hFFFF
`define FSBS_ROM_BYTES      256
`define FSBS_LOADER_BYTES   512
// Reset values
`define FSBS_RST_CMDSTAT    8'h00
`define FSBS_RST_BOOTVEC    8'h1F
// Timing
`define FSBS_CLK_HZ         25000000
`define FSBS_EP_TIME_US     4000
`define FSBS_EP_CYCLES      ((`FSBS_EP_TIME_US * (`FSBS_CLK_HZ / 1000)) / 1000)
`define FSBS_PWRUP_CYCLES   1000
`define FSBS_PULSE_MIN      4
`define FSBS_PULSE_MAX      1000
`define FSBS_PULSE_GAP_MAX  5000
`define FSBS_PULSE_COUNT    3
`endif

//--- hdl/fsbs_ep_engine.v
// Erase-program cycle timer with abort and fault reporting
`timescale 1ns/1ns
`default_nettype none
`include "fsbs_defines.vh"
module fsbs_ep_engine
#(
    parameter EP_CYCLES = `FSBS_EP_CYCLES
)
(
    // Clock and reset
    input  wire        sys_clk_i,
    input  wire        rstn_i,
    // Control
    input  wire        start_i,
    input  wire        irq_i,
    input  wire        brownout_i,
    input  wire        hv_fault_i,
    // Status
    output reg         busy_o,
    output reg         done_o,
    output reg         aborted_o,
    output reg         hv_abort_o
);
    reg [31:0] cnt;
    always @(posedge sys_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            busy_o     <= 1'b0;
            done_o     <= 1'b0;
            aborted_o  <= 1'b0;
            hv_abort_o <= 1'b0;
            cnt        <= 32'h00000000;
        end
        else
        begin
            done_o     <= 1'b0;
            aborted_o  <= 1'b0;
            hv_abort_o <= 1'b0;
            if (start_i && !busy_o)
            begin
                busy_o <= 1'b1;
                cnt    <= 32'h00000000;
            end
            else if (busy_o)
            begin
                if (irq_i || brownout_i || hv_fault_i)
                begin
                    busy_o     <= 1'b0;
                    done_o     <= 1'b1;
                    aborted_o  <= irq_i;
                    hv_abort_o <= irq_i | brownout_i;
                end
                else if (cnt >= EP_CYCLES - 1)
                begin
                    busy_o <= 1'b0;
                    done_o <= 1'b1;
                end
                else
                    cnt <= cnt + 32'h00000001;
            end
        end
    end
endmodule
`default_nettype wire

//--- hdl/fsbs_pulse_detect.v
// Reset-pin pulse pattern detector for forced loader entry
`timescale 1ns/1ns
`default_nettype none
`include "fsbs_defines.vh"
module fsbs_pulse_detect
#(
    parameter PWRUP_CYCLES = `FSBS_PWRUP_CYCLES,
    parameter GAP_MAX      = `FSBS_PULSE_GAP_MAX
)
(
    // Clock and reset
    input  wire        sys_clk_i,
    input  wire        rstn_i,
    // Pin and result
    input  wire        pin_low_i,
    output reg         done_o,
    output reg         loader_o
);
    localparam S_HOLD  = 4'b0001;
    localparam S_HIGH  = 4'b0010;
    localparam S_PULSE = 4'b0100;
    localparam S_DONE  = 4'b1000;
    reg [3:0]  state;
    reg [15:0] cnt;
    reg [2:0]  pulses;
    // Pattern must end with a quiet high gap so extra pulses are seen
    always @(posedge sys_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            state    <= S_HOLD;
            cnt      <= 16'h0000;
            pulses   <= 3'h0;
            done_o   <= 1'b0;
            loader_o <= 1'b0;
        end
        else
        begin
            case (state)
            S_HOLD:
            begin
                if (pin_low_i)
                    cnt <= (cnt == 16'hFFFF) ? cnt : cnt + 16'h0001;
                else if (cnt >= PWRUP_CYCLES)
                begin
                    state <= S_HIGH;
                    cnt   <= 16'h0000;
                end
                else
                begin
                    state  <= S_DONE;
                    done_o <= 1'b1;
                end
            end
            S_HIGH:
            begin
                if (pin_low_i)
                begin
                    state <= S_PULSE;
                    cnt   <= 16'h0000;
                end
                else if (cnt >= GAP_MAX)
                begin
                    state    <= S_DONE;
                    done_o   <= 1'b1;
                    loader_o <= (pulses == `FSBS_PULSE_COUNT);
                end
                else
                    cnt <= cnt + 16'h0001;
            end
            S_PULSE:
            begin
                if (pin_low_i)
                    cnt <= (cnt == 16'hFFFF) ? cnt : cnt + 16'h0001;
                else
                begin
                    cnt   <= 16'h0000;
                    state <= S_HIGH;
                    // Badly timed pulse spoils the count
                    if (cnt + 16'h0001 < `FSBS_PULSE_MIN ||
                        cnt >= `FSBS_PULSE_MAX)
                        pulses <= 3'h7;
                    else if (pulses != 3'h7)
                        pulses <= pulses + 3'h1;
                end
            end
            S_DONE:
                done_o <= 1'b1;
            default:
                state <= S_DONE;
            endcase
        end
    end
endmodule
`default_nettype wire

//--- hdl/fsbs_top.v
// Flash command/status register, boot start select and APB slave
// Function
// - Interrupt or reset abort sets bit 0
// - Secured target operation sets bit 1
// - High voltage generator fault sets bit 2
// - Interrupt or brown-out during cycle sets 3
// - Start with brown-out detector off sets 3
// - Boot bit zero starts at 0000H
// - Boot bit one starts at vector:00H
// - Boot ROM mapped at FF00 to FFFF
// - Held reset then three pulses force loader
// - Loader entry acts like boot bit set
// - Factory loader in top 512 code bytes
// - External programmer uses two-wire serial path
// - Command write clears all status flags
// - 68H starts cycle, 00H clears page buffer
// - CPU held in program idle during cycle
`timescale 1ns/1ns
`default_nettype none
`include "fsbs_defines.vh"
module fsbs_top
#(
    parameter EP_CYCLES    = `FSBS_EP_CYCLES,
    parameter PWRUP_CYCLES = `FSBS_PWRUP_CYCLES,
    parameter GAP_MAX      = `FSBS_PULSE_GAP_MAX,
    parameter [7:0] BOOT_VECTOR_RST = `FSBS_RST_BOOTVEC
)
(
    // Clock and reset
    input  wire        sys_clk_i,
    input  wire        rstn_i,
    // APB slave
    input  wire        psel_i,
    input  wire        penable_i,
    input  wire        pwrite_i,
    input  wire [11:0] paddr_i,
    input  wire [31:0] pwdata_i,
    output reg  [31:0] prdata_o,
    output reg         pready_o,
    output reg         pslverr_o,
    // Flash environment
    input  wire        cpu_irq_i,
    input  wire        brownout_i,
    input  wire        bod_enabled_i,
    input  wire        hv_fault_i,
    input  wire        target_secured_i,
    input  wire        rst_pin_low_i,
    input  wire        boot_status_i,
    input  wire [7:0]  boot_vector_i,
    input  wire [15:0] fetch_addr_i,
    // Outputs
    output reg         cpu_idle_o,
    output reg         page_clear_o,
    output reg         start_valid_o,
    output reg  [15:0] start_addr_o,
    output reg         boot_rom_sel_o,
    output reg         icp_enable_o,
    output reg         irq_o
);
    reg  [3:0]  status;
    reg  [7:0]  last_cmd;
    reg  [3:0]  irq_stat;
    reg  [3:0]  irq_mask;
    reg         ctrl_icp;
    reg         ctrl_reset_abort;
    reg         pwr_abort_seen;
    reg         ep_start;
    reg  [3:0]  next_status;
    reg  [3:0]  ev;
    reg  [31:0] rd;
    wire        ep_busy;
    wire        ep_done;
    wire        ep_aborted;
    wire        ep_hva;
    wire        pd_done;
    wire        pd_loader;
    wire        wr_acc;
    wire        rd_acc;
    wire        sec_ok;
    function addr_hit;
        input [11:0] a;
        input [11:0] b;
        begin
            addr_hit = (a == b);
        end
    endfunction
    assign wr_acc = psel_i & penable_i & pwrite_i & pready_o;
    assign rd_acc = psel_i & penable_i & ~pwrite_i & pready_o;
    assign sec_ok = 1'b1;
    fsbs_ep_engine
    #(
        .EP_CYCLES  (EP_CYCLES)
    )
    u_ep
    (
        .sys_clk_i  (sys_clk_i),
        .rstn_i     (rstn_i),
        .start_i    (ep_start),
        .irq_i      (cpu_irq_i),
        .brownout_i (brownout_i),
        .hv_fault_i (hv_fault_i),
        .busy_o     (ep_busy),
        .done_o     (ep_done),
        .aborted_o  (ep_aborted),
        .hv_abort_o (ep_hva)
    );
    fsbs_pulse_detect
    #(
        .PWRUP_CYCLES (PWRUP_CYCLES),
        .GAP_MAX      (GAP_MAX)
    )
    u_pd
    (
        .sys_clk_i  (sys_clk_i),
        .rstn_i     (rstn_i),
        .pin_low_i  (rst_pin_low_i),
        .done_o     (pd_done),
        .loader_o   (pd_loader)
    );
    wire cmd_wr = wr_acc & addr_hit(paddr_i, `FSBS_ADDR_CMDSTAT);
    wire cmd_ep = cmd_wr &
                  (pwdata_i[7:0] == `FSBS_CMD_ERASE_PGM);
    // Status events this cycle; set beats the command clear
    always @*
    begin
        ev = 4'h0;
        ev[`FSBS_BIT_OI]  = ep_aborted | pwr_abort_seen;
        ev[`FSBS_BIT_SV]  = cmd_ep & target_secured_i;
        ev[`FSBS_BIT_HVE] = hv_fault_i & ep_busy;
        ev[`FSBS_BIT_HVA] = ep_hva | (cmd_ep & ~bod_enabled_i);
        next_status = status;
        if (cmd_wr)
            next_status = 4'h0;
        next_status = next_status | ev;
    end
    always @*
    begin
        rd = 32'h00000000;
        if (addr_hit(paddr_i, `FSBS_ADDR_CMDSTAT))
            rd = {28'h0000000, status};
        else if (addr_hit(paddr_i, `FSBS_ADDR_BOOTCFG))
            rd = {22'h000000, pd_loader, boot_status_i,
                  boot_vector_i};
        else if (addr_hit(paddr_i, `FSBS_ADDR_START))
            rd = {15'h0000, start_valid_o, start_addr_o};
        else if (addr_hit(paddr_i, `FSBS_ADDR_IRQ_STAT))
            rd = {28'h0000000, irq_stat};
        else if (addr_hit(paddr_i, `FSBS_ADDR_IRQ_MASK))
            rd = {28'h0000000, irq_mask};
        else if (addr_hit(paddr_i, `FSBS_ADDR_CTRL))
            rd = {22'h000000, last_cmd, ctrl_reset_abort, ctrl_icp};
    end
    // Answer one cycle after setup; stall while a cycle runs and in
    // its done cycle, so read data carries the final status
    always @(posedge sys_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            pready_o  <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o  <= 32'h00000000;
        end
        else
        begin
            pready_o  <= 1'b0;
            pslverr_o <= 1'b0;
            if (psel_i & ~pready_o & ~ep_busy & ~ep_start & ~ep_done)
            begin
                pready_o  <= 1'b1;
                prdata_o  <= rd;
                pslverr_o <= ~(addr_hit(paddr_i, `FSBS_ADDR_CMDSTAT) |
                    addr_hit(paddr_i, `FSBS_ADDR_BOOTCFG) |
                    addr_hit(paddr_i, `FSBS_ADDR_START) |
                    addr_hit(paddr_i, `FSBS_ADDR_IRQ_STAT) |
                    addr_hit(paddr_i, `FSBS_ADDR_IRQ_MASK) |
                    addr_hit(paddr_i, `FSBS_ADDR_CTRL));
            end
            else if (pready_o)
                prdata_o <= 32'h00000000;
        end
    end
    always @(posedge sys_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            status           <= 4'h0;
            last_cmd         <= `FSBS_RST_CMDSTAT;
            irq_stat         <= 4'h0;
            irq_mask         <= 4'h0;
            ctrl_icp         <= 1'b0;
            ctrl_reset_abort <= 1'b0;
            pwr_abort_seen   <= 1'b0;
            ep_start         <= 1'b0;
            page_clear_o     <= 1'b0;
            cpu_idle_o       <= 1'b0;
            irq_o            <= 1'b0;
        end
        else
        begin
            status       <= next_status;
            ep_start     <= cmd_ep & ~target_secured_i & sec_ok;
            page_clear_o <= cmd_wr &
                (pwdata_i[7:0] == `FSBS_CMD_LOAD);
            cpu_idle_o   <= ep_start | (ep_busy & ~ep_done);
            // Reset-interrupted cycle reported once, software flagged
            pwr_abort_seen <= 1'b0;
            if (ctrl_reset_abort)
            begin
                pwr_abort_seen   <= 1'b1;
                ctrl_reset_abort <= 1'b0;
            end
            if (cmd_wr)
                last_cmd <= pwdata_i[7:0];
            if (wr_acc & addr_hit(paddr_i, `FSBS_ADDR_IRQ_MASK))
                irq_mask <= pwdata_i[3:0];
            if (wr_acc & addr_hit(paddr_i, `FSBS_ADDR_CTRL))
            begin
                ctrl_icp         <= pwdata_i[0];
                ctrl_reset_abort <= pwdata_i[1];
            end
            if (wr_acc & addr_hit(paddr_i, `FSBS_ADDR_IRQ_STAT))
                irq_stat <= (irq_stat & ~pwdata_i[3:0]) | ev;
            else
                irq_stat <= irq_stat | ev;
            irq_o <= |((irq_stat | ev) & irq_mask &
                ~(wr_acc & addr_hit(paddr_i, `FSBS_ADDR_IRQ_STAT) ?
                  pwdata_i[3:0] & ~ev : 4'h0));
        end
    end
    // Start address chosen once pulse detection settles
    always @(posedge sys_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            start_valid_o  <= 1'b0;
            start_addr_o   <= `FSBS_APP_START;
            boot_rom_sel_o <= 1'b0;
            icp_enable_o   <= 1'b0;
        end
        else
        begin
            if (pd_done & ~start_valid_o)
            begin
                start_valid_o <= 1'b1;
                if (boot_status_i | pd_loader)
                    start_addr_o <= {boot_vector_i, `FSBS_VEC_LOW};
                else
                    start_addr_o <= `FSBS_APP_START;
            end
            boot_rom_sel_o <= (fetch_addr_i >= `FSBS_ROM_BASE) &&
                (fetch_addr_i <= `FSBS_ROM_TOP);
            icp_enable_o   <= ctrl_icp;
        end
    end
endmodule
`default_nettype wire

//--- testbench/fsbs_fw_model.sv
// Firmware-side bus master model for the flash status block
`timescale 1ns/1ns
`default_nettype none
module fsbs_fw_model
(
    // Clock
    input  wire logic        sys_clk_i,
    // Bus master side
    output var  logic        psel_o,
    output var  logic        penable_o,
    output var  logic        pwrite_o,
    output var  logic [11:0] paddr_o,
    output var  logic [31:0] pwdata_o,
    input  wire logic        pready_i,
    input  wire logic [31:0] prdata_i
);
    initial
    begin
        psel_o = 1'b0;
        penable_o = 1'b0;
        pwrite_o = 1'b0;
        paddr_o = 12'h000;
        pwdata_o = 32'h0000_0000;
    end

    // Waits for pready however long; only the bench watchdog ends a stall
    task automatic xfer(input logic w, input logic [11:0] a,
                        input logic [31:0] d, output logic [31:0] q);
        @(posedge sys_clk_i);
        psel_o <= 1'b1;
        pwrite_o <= w;
        paddr_o <= a;
        pwdata_o <= d;
        @(posedge sys_clk_i);
        penable_o <= 1'b1;
        do
            @(posedge sys_clk_i);
        while (pready_i !== 1'b1);
        q = prdata_i;
        psel_o <= 1'b0;
        penable_o <= 1'b0;
    endtask

    // Only the four low status bits count as failure
    function automatic logic op_failed(input logic [31:0] s);
        return |(s[7:0] & 8'h0F);
    endfunction
endmodule
`default_nettype wire

//--- testbench/fsbs_props.sv
// Assertion checker for the flash status and boot select block
`timescale 1ns/1ns
`default_nettype none
module fsbs_props
#(
    parameter EP_CYCLES = 50
)
(
    // Clock, reset and bus
    input wire logic        sys_clk_i,
    input wire logic        rstn_i,
    input wire logic        psel_i,
    input wire logic        penable_i,
    input wire logic        pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [31:0] prdata_o,
    input wire logic        pready_o,
    // Flash side
    input wire logic        cpu_irq_i,
    input wire logic        brownout_i,
    input wire logic        bod_enabled_i,
    input wire logic        hv_fault_i,
    input wire logic        target_secured_i,
    input wire logic        boot_status_i,
    input wire logic [7:0]  boot_vector_i,
    input wire logic [15:0] fetch_addr_i,
    input wire logic        cpu_idle_o,
    input wire logic        page_clear_o,
    input wire logic        start_valid_o,
    input wire logic [15:0] start_addr_o,
    input wire logic        boot_rom_sel_o,
    input wire logic        icp_enable_o
);
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rstn_i);

    logic [15:0] idle_cnt;
    always @(posedge sys_clk_i or negedge rstn_i)
        if (!rstn_i)
            idle_cnt <= 16'h0000;
        else
            idle_cnt <= cpu_idle_o ? idle_cnt + 16'h0001 : 16'h0000;

    sequence s_wr(a);
        psel_i && penable_i && pready_o && pwrite_i && paddr_i == a;
    endsequence
    sequence s_ep_clean;
        s_wr(12'h000) ##0 (pwdata_i[7:0] == 8'h68 && !target_secured_i
            && bod_enabled_i && !cpu_irq_i && !brownout_i && !hv_fault_i);
    endsequence

    property p_ep_start;
        s_ep_clean |-> ##2 cpu_idle_o;
    endproperty
    a_ep_start: assert property (p_ep_start) else $error("no idle");
    property p_page_clr;
        s_wr(12'h000) ##0 pwdata_i[7:0] == 8'h00 |-> ##[0:2] page_clear_o;
    endproperty
    a_page_clr: assert property (p_page_clr) else $error("no clr");
    property p_rsv_zero;
        psel_i && pready_o && !pwrite_i && paddr_i == 12'h000
            |-> prdata_o[31:4] == 28'h0;
    endproperty
    a_rsv_zero: assert property (p_rsv_zero) else $error("rsv");
    property p_irq_end;
        cpu_idle_o && cpu_irq_i |-> ##[0:3] !cpu_idle_o;
    endproperty
    a_irq_end: assert property (p_irq_end) else $error("no abort");
    property p_vec;
        start_valid_o && boot_status_i
            |-> start_addr_o == {boot_vector_i, 8'h00};
    endproperty
    a_vec: assert property (p_vec) else $error("vector start");
    property p_app;
        start_valid_o && !boot_status_i |-> start_addr_o == 16'h0000
            || start_addr_o == {boot_vector_i, 8'h00};
    endproperty
    a_app: assert property (p_app) else $error("app start");
    property p_rom;
        1'b1 |=> boot_rom_sel_o == ($past(fetch_addr_i) >= 16'hFF00);
    endproperty
    a_rom: assert property (p_rom) else $error("rom select");
    property p_icp;
        s_wr(12'h014) |-> ##2 icp_enable_o == $past(pwdata_i[0], 2);
    endproperty
    a_icp: assert property (p_icp) else $error("icp enable");
    property p_idle_max;
        idle_cnt <= EP_CYCLES + 2;
    endproperty
    a_idle_max: assert property (p_idle_max) else $error("idle");
endmodule
bind fsbs_top fsbs_props #(.EP_CYCLES(EP_CYCLES)) fsbs_props_inst (.*);
`default_nettype wire

//--- testbench/test_flash_status_boot_select.sv
// Testbench for the flash status and boot select block
`timescale 1ns/1ns
`default_nettype none
`include "fsbs_defines.vh"
module test_flash_status_boot_select;
    logic        sys_clk_i = 1'b0, rstn_i = 1'b0;
    logic        cpu_irq_i = 1'b0, brownout_i = 1'b0, hv_fault_i = 1'b0;
    logic        bod_enabled_i = 1'b1, target_secured_i = 1'b0;
    logic        rst_pin_low_i = 1'b0, boot_status_i = 1'b0;
    logic [7:0]  boot_vector_i = 8'h3C;
    logic [15:0] fetch_addr_i = 16'h0000, start_addr_o;
    logic        psel_i, penable_i, pwrite_i, pready_o, pslverr_o;
    logic [11:0] paddr_i;
    logic [31:0] pwdata_i, prdata_o;
    logic        cpu_idle_o, page_clear_o, start_valid_o, irq_o;
    logic        boot_rom_sel_o, icp_enable_o;
    int          n_mismatch = 0, num_checks = 0;

    always #20 sys_clk_i = ~sys_clk_i;

    fsbs_top #(.EP_CYCLES(50), .PWRUP_CYCLES(20), .GAP_MAX(40))
        fsbs_top_inst (.*);
    fsbs_fw_model fsbs_fw_model_inst (.sys_clk_i(sys_clk_i),
        .psel_o(psel_i), .penable_o(penable_i), .pwrite_o(pwrite_i),
        .paddr_o(paddr_i), .pwdata_o(pwdata_i), .pready_i(pready_o),
        .prdata_i(prdata_o));

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] got,
                       input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic rd(input logic [11:0] a, output logic [31:0] q);
        fsbs_fw_model_inst.xfer(1'b0, a, 32'h0, q);
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        fsbs_fw_model_inst.xfer(1'b1, a, d, q);
    endtask

    // Pulses on the reset pin after a held-low power-up
    task automatic t_boot(input int n, input logic bs);
        logic [31:0] q;
        logic        ld;
        ld = (n == 3);
        boot_status_i <= bs;
        rst_pin_low_i <= (n > 0);
        rstn_i <= 1'b0;
        repeat (16) @(posedge sys_clk_i);
        rstn_i <= 1'b1;
        repeat (30) @(posedge sys_clk_i);
        rst_pin_low_i <= 1'b0;
        repeat (n)
        begin
            repeat (10) @(posedge sys_clk_i);
            rst_pin_low_i <= 1'b1;
            repeat (10) @(posedge sys_clk_i);
            rst_pin_low_i <= 1'b0;
        end
        repeat (60) @(posedge sys_clk_i);
        rd(`FSBS_ADDR_START, q);
        chk("start", q, {15'h0, 1'b1, (bs | ld) ? {boot_vector_i, 8'h00}
            : 16'h0000});
        rd(`FSBS_ADDR_BOOTCFG, q);
        chk("bootcfg", q, {22'h0, ld, bs, boot_vector_i});
        rd(`FSBS_ADDR_CMDSTAT, q);
        chk("status", q, 32'h0);
        $display("test boot %0d done", n);
    endtask

    // Erase-program with an event injected mid-cycle
    task automatic t_ep(input logic [2:0] ev, input logic sec,
                        input logic bod, input logic [7:0] exp);
        logic [31:0] q;
        target_secured_i <= sec;
        bod_enabled_i <= bod;
        wr(`FSBS_ADDR_CMDSTAT, 32'h68);
        repeat (5) @(posedge sys_clk_i);
        {hv_fault_i, brownout_i, cpu_irq_i} <= ev;
        rd(`FSBS_ADDR_CMDSTAT, q);
        {hv_fault_i, brownout_i, cpu_irq_i} <= 3'b000;
        chk("status", q, {24'h0, exp});
        chk("fail", fsbs_fw_model_inst.op_failed(q), exp != 0);
        wr(`FSBS_ADDR_CMDSTAT, 32'h00);
        rd(`FSBS_ADDR_CMDSTAT, q);
        chk("cleared", q, 32'h0);
        $display("test ep %h done", exp);
    endtask

    // Sticky event status, mask and write-one clear
    task automatic t_irq;
        logic [31:0] q;
        rd(`FSBS_ADDR_IRQ_STAT, q);
        chk("stat set", q, 32'h0000000F);
        wr(`FSBS_ADDR_IRQ_MASK, 32'h0);
        repeat (2) @(posedge sys_clk_i);
        chk("irq masked", irq_o, 1'b0);
        wr(`FSBS_ADDR_IRQ_MASK, 32'hFFFF_FFFF);
        repeat (2) @(posedge sys_clk_i);
        chk("irq open", irq_o, 1'b1);
        wr(`FSBS_ADDR_IRQ_STAT, q);
        rd(`FSBS_ADDR_IRQ_STAT, q);
        chk("stat clr", q, 32'h0);
        chk("irq clr", irq_o, 1'b0);
        $display("test irq done");
    endtask

    task automatic t_rom_icp;
        logic [31:0] q;
        fetch_addr_i <= `FSBS_ROM_BASE;
        repeat (2) @(posedge sys_clk_i);
        chk("rom", boot_rom_sel_o, 1'b1);
        fetch_addr_i <= 16'hFEFF;
        repeat (2) @(posedge sys_clk_i);
        chk("no rom", boot_rom_sel_o, 1'b0);
        wr(`FSBS_ADDR_CTRL, 32'h3);
        repeat (2) @(posedge sys_clk_i);
        chk("icp", icp_enable_o, 1'b1);
        rd(`FSBS_ADDR_CMDSTAT, q);
        chk("reset abort", q, 32'h1);
        rd(12'h018, q);
        chk("unmapped", q, 32'h0);
        chk("slverr", pslverr_o, 1'b1);
        $display("test rom icp done");
    endtask

    initial
    begin
        #400000;
        n_mismatch++;
        report_and_stop;
    end

    initial
    begin
        t_boot(0, 1'b0);
        t_ep(3'b000, 1'b0, 1'b1, 8'h00);
        t_ep(3'b001, 1'b0, 1'b1, 8'h09);
        t_ep(3'b010, 1'b0, 1'b1, 8'h08);
        t_ep(3'b100, 1'b0, 1'b1, 8'h04);
        t_ep(3'b000, 1'b1, 1'b1, 8'h02);
        t_ep(3'b000, 1'b0, 1'b0, 8'h08);
        t_irq;
        t_rom_icp;
        t_boot(2, 1'b0);
        t_boot(4, 1'b0);
        t_boot(3, 1'b0);
        t_boot(0, 1'b1);
        // Boot status cleared again so the application starts at zero
        t_boot(0, 1'b0);
        report_and_stop;
    end
endmodule
`default_nettype wire
